// ==== verilog/dsc_map.svh ====
`ifndef DSC_MAP_SVH
`define DSC_MAP_SVH
// program request word fields
`define DSC_CMD_XMIT 15
`define DSC_CMD_RSV_HI 13
`define DSC_CMD_RSV_LO 6
`define DSC_CMD_SEL1 4
`define DSC_CMD_PST1 2
`define DSC_CMD_WR1 0
// setup word fields
`define DSC_CFG_LED 15
`define DSC_CFG_SWAP 14
`define DSC_CFG_RATE_HI 13
`define DSC_CFG_RATE_LO 12
`define DSC_CFG_VEL 11
`define DSC_CFG_DIR 10
`define DSC_CFG_GRAY 9
`define DSC_CFG_NEG 8
`define DSC_CFG_FN_HI 7
`define DSC_CFG_FN_LO 4
`define DSC_CFG_LAY_HI 3
`define DSC_CFG_LAY_LO 0
`define DSC_CFG_RESET 16'h0000
// input function codes
`define DSC_FN_GP 4'h0
`define DSC_FN_PST_R 4'h1
`define DSC_FN_PST_F 4'h2
`define DSC_FN_PST_B 4'h3
`define DSC_FN_CAP_R 4'h4
`define DSC_FN_CAP_F 4'h5
`define DSC_FN_CAP_B 4'h6
// data layout codes
`define DSC_LAY_DV_RAW 4'h0
`define DSC_LAY_DV_VEL 4'h1
`define DSC_LAY_VEL_RAW 4'h2
`define DSC_LAY_DV_CAP 4'h3
`define DSC_LAY_VEL_CAP 4'h4
// timing
`define DSC_CLK_HZ 20000000
`define DSC_VEL_SLOW_MS 160
`define DSC_VEL_FAST_MS 24
`endif

// ==== verilog/dsc_pkg.sv ====
package dsc_pkg;
    typedef enum logic [1:0] {
        DSC_IDLE = 2'b01,
        DSC_ACK  = 2'b10
    } dsc_state_e;
    typedef logic [31:0] dsc_word_t;
endpackage

// ==== verilog/dsc_cmd_cfg.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dsc_map.svh"
module dsc_cmd_cfg #(
    parameter int VEL_SLOW_CYC =
        `DSC_VEL_SLOW_MS * (`DSC_CLK_HZ / 1000),
    parameter int VEL_FAST_CYC =
        `DSC_VEL_FAST_MS * (`DSC_CLK_HZ / 1000)
) (
    input  wire logic        I_CLOCK,
    input  wire logic        I_NRST,
    input  wire logic [15:0] I_CMD,
    input  wire logic [15:0] I_CH1_CFG,
    input  wire logic [15:0] I_CH2_CFG,
    input  wire logic [31:0] I_CH1_PRESET,
    input  wire logic [31:0] I_CH2_PRESET,
    input  wire logic [31:0] I_CH1_ENC,
    input  wire logic [31:0] I_CH2_ENC,
    input  wire logic        I_CH1_IN,
    input  wire logic        I_CH2_IN,
    input  wire logic        I_PROTO_HIGH_FIRST,
    output logic             O_ACK,
    output logic [31:0]      O_CH1_VALUE1,
    output logic [31:0]      O_CH1_VALUE2,
    output logic [31:0]      O_CH2_VALUE1,
    output logic [31:0]      O_CH2_VALUE2,
    output logic             O_CH1_CMD_ERR,
    output logic             O_CH2_CMD_ERR,
    output logic             O_CH1_CFG_ERR,
    output logic             O_CH2_CFG_ERR,
    output logic             O_CH1_CAPTURED,
    output logic             O_CH2_CAPTURED,
    output logic             O_CH1_IN_STATE,
    output logic             O_CH2_IN_STATE,
    output logic             O_CH1_LED_OFF,
    output logic             O_CH2_LED_OFF,
    output logic [1:0]       O_CH1_CLK_RATE,
    output logic [1:0]       O_CH2_CLK_RATE
);
    // gray to binary conversion
    function automatic dsc_pkg::dsc_word_t g2b(
        input dsc_pkg::dsc_word_t g);
        dsc_pkg::dsc_word_t b;
        b[31] = g[31];
        for (int i = 30; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // polarity, code and direction of one encoder word
    function automatic dsc_pkg::dsc_word_t enc_decode(
        input logic [15:0]        f,
        input dsc_pkg::dsc_word_t e);
        dsc_pkg::dsc_word_t r;
        r = f[`DSC_CFG_NEG] ? ~e : e;
        if (f[`DSC_CFG_GRAY]) begin
            r = g2b(r);
        end
        return f[`DSC_CFG_DIR] ? -r : r;
    endfunction

    // reserved code checks
    function automatic logic fn_bad(input logic [3:0] f);
        return f > `DSC_FN_CAP_B;
    endfunction
    function automatic logic lay_bad(input logic [3:0] l);
        return l > `DSC_LAY_VEL_CAP;
    endfunction

    dsc_pkg::dsc_state_e state;
    dsc_pkg::dsc_state_e next_state;
    logic                xmit_prev;
    logic                next_xmit_prev;
    logic                ack;
    logic                next_ack;
    logic                accept;
    logic                cmd_ok;
    logic                xmit;

    assign xmit = I_CMD[`DSC_CMD_XMIT];

    // handshake: take data on transmit rise only
    always_comb begin
        next_xmit_prev = xmit;
        next_state = state;
        next_ack = ack;
        accept = 1'b0;
        unique case (state)
            dsc_pkg::DSC_IDLE: begin
                if (xmit && !xmit_prev) begin
                    accept = 1'b1;
                    next_state = dsc_pkg::DSC_ACK;
                    next_ack = 1'b1;
                end
            end
            dsc_pkg::DSC_ACK: begin
                if (!xmit) begin
                    next_state = dsc_pkg::DSC_IDLE;
                    next_ack = 1'b0;
                end
            end
        endcase
        cmd_ok = accept &&
            (I_CMD[`DSC_CMD_RSV_HI:`DSC_CMD_RSV_LO] == '0);
    end

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            state <= dsc_pkg::DSC_IDLE;
            xmit_prev <= 1'b0;
            ack <= 1'b0;
        end else begin
            state <= next_state;
            xmit_prev <= next_xmit_prev;
            ack <= next_ack;
        end
    end

    assign O_ACK = ack;

    // per channel setup, data path and status
    for (genvar c = 0; c < 2; c++) begin : ch
        logic [15:0] cfg_in;
        logic [31:0] pst_in;
        logic [31:0] enc_in;
        logic        in_pin;
        logic        wr;
        logic        pst;
        logic        sel;
        logic        cfg_bad;
        logic [15:0] cfg;
        logic [15:0] next_cfg;
        logic [3:0]  lay;
        logic [3:0]  next_lay;
        logic [31:0] preset;
        logic [31:0] next_preset;
        logic [31:0] offset;
        logic [31:0] next_offset;
        logic [31:0] pos;
        logic [31:0] dval;
        logic [31:0] cap;
        logic [31:0] next_cap;
        logic        captured;
        logic        next_captured;
        logic        in_prev;
        logic [31:0] vel;
        logic [31:0] next_vel;
        logic [31:0] vel_ref;
        logic [31:0] next_vel_ref;
        logic [31:0] vel_cnt;
        logic [31:0] next_vel_cnt;
        logic        cmd_err;
        logic        next_cmd_err;
        logic        cfg_err;
        logic        next_cfg_err;
        logic [31:0] val1;
        logic [31:0] next_val1;
        logic [31:0] val2;
        logic [31:0] next_val2;
        logic [31:0] w1;
        logic [31:0] w2;
        logic        rise;
        logic        fall;
        logic        hi_first;
        logic [31:0] lim;

        assign cfg_in = (c == 0) ? I_CH1_CFG : I_CH2_CFG;
        assign pst_in = (c == 0) ? I_CH1_PRESET : I_CH2_PRESET;
        assign enc_in = (c == 0) ? I_CH1_ENC : I_CH2_ENC;
        assign in_pin = (c == 0) ? I_CH1_IN : I_CH2_IN;
        assign wr  = I_CMD[`DSC_CMD_WR1 + c];
        assign pst = I_CMD[`DSC_CMD_PST1 + c];
        assign sel = I_CMD[`DSC_CMD_SEL1 + c];
        assign cfg_bad =
            fn_bad(cfg_in[`DSC_CFG_FN_HI:`DSC_CFG_FN_LO]) ||
            lay_bad(cfg_in[`DSC_CFG_LAY_HI:`DSC_CFG_LAY_LO]);
        assign rise = in_pin && !in_prev;
        assign fall = !in_pin && in_prev;

        // encoder word decoding
        always_comb begin
            pos = enc_decode(cfg, enc_in);
            dval = pos + offset;
        end

        // programming, edges, capture and velocity
        always_comb begin
            next_cfg = cfg;
            next_lay = lay;
            next_preset = preset;
            next_offset = offset;
            next_cap = cap;
            next_captured = captured;
            next_cmd_err = cmd_err;
            next_cfg_err = cfg_err;
            next_vel = vel;
            next_vel_ref = vel_ref;
            next_vel_cnt = vel_cnt + 32'h1;
            // a capture in the same cycle outweighs the clear
            if (accept) begin
                next_captured = 1'b0;
            end
            // discrete input functions
            unique case (cfg[`DSC_CFG_FN_HI:`DSC_CFG_FN_LO])
                `DSC_FN_PST_R: if (rise) begin
                    next_offset = preset - pos;
                end
                `DSC_FN_PST_F: if (fall) begin
                    next_offset = preset - pos;
                end
                `DSC_FN_PST_B: if (rise || fall) begin
                    next_offset = preset - pos;
                end
                `DSC_FN_CAP_R: if (rise && !captured) begin
                    next_cap = dval;
                    next_captured = 1'b1;
                end
                `DSC_FN_CAP_F: if (fall && !captured) begin
                    next_cap = dval;
                    next_captured = 1'b1;
                end
                `DSC_FN_CAP_B:
                    if ((rise || fall) && !captured) begin
                        next_cap = dval;
                        next_captured = 1'b1;
                    end
                default: ;
            endcase
            // velocity sampling period
            if (vel_cnt >= lim - 32'h1) begin
                next_vel = dval - vel_ref;
                next_vel_ref = dval;
                next_vel_cnt = '0;
            end
            if (accept) begin
                next_cmd_err = !cmd_ok;
            end
            if (cmd_ok) begin
                if (wr) begin
                    next_cfg_err = cfg_bad;
                end
                if (wr && !cfg_bad) begin
                    next_cfg = cfg_in;
                    next_preset = pst_in;
                end
                if (pst) begin
                    // new preset first, decoded under the new setup
                    if (wr && !cfg_bad) begin
                        next_offset = pst_in
                            - enc_decode(cfg_in, enc_in);
                    end else begin
                        next_offset = preset - pos;
                    end
                end
                if (sel) begin
                    if (lay_bad(cfg_in[`DSC_CFG_LAY_HI:
                        `DSC_CFG_LAY_LO])) begin
                        next_cfg_err = 1'b1;
                    end else begin
                        next_lay = cfg_in[`DSC_CFG_LAY_HI:
                            `DSC_CFG_LAY_LO];
                    end
                end
            end
        end

        assign lim = cfg[`DSC_CFG_VEL] ?
            VEL_FAST_CYC : VEL_SLOW_CYC;

        // reported value selection
        always_comb begin
            w1 = dval;
            w2 = enc_in;
            unique case (lay)
                `DSC_LAY_DV_RAW: begin
                    w1 = dval;
                    w2 = enc_in;
                end
                `DSC_LAY_DV_VEL: begin
                    w1 = dval;
                    w2 = vel;
                end
                `DSC_LAY_VEL_RAW: begin
                    w1 = vel;
                    w2 = enc_in;
                end
                `DSC_LAY_DV_CAP: begin
                    w1 = dval;
                    w2 = cap;
                end
                `DSC_LAY_VEL_CAP: begin
                    w1 = vel;
                    w2 = cap;
                end
                default: ;
            endcase
            hi_first = I_PROTO_HIGH_FIRST ^
                cfg[`DSC_CFG_SWAP];
            next_val1 = hi_first ? {w1[15:0], w1[31:16]} : w1;
            next_val2 = hi_first ? {w2[15:0], w2[31:16]} : w2;
        end

        always_ff @(posedge I_CLOCK or negedge I_NRST) begin
            if (!I_NRST) begin
                cfg <= `DSC_CFG_RESET;
                lay <= `DSC_LAY_DV_RAW;
                preset <= '0;
                offset <= '0;
                cap <= '0;
                captured <= 1'b0;
                in_prev <= 1'b0;
                vel <= '0;
                vel_ref <= '0;
                vel_cnt <= '0;
                cmd_err <= 1'b0;
                cfg_err <= 1'b0;
                val1 <= '0;
                val2 <= '0;
            end else begin
                cfg <= next_cfg;
                lay <= next_lay;
                preset <= next_preset;
                offset <= next_offset;
                cap <= next_cap;
                captured <= next_captured;
                in_prev <= in_pin;
                vel <= next_vel;
                vel_ref <= next_vel_ref;
                vel_cnt <= next_vel_cnt;
                cmd_err <= next_cmd_err;
                cfg_err <= next_cfg_err;
                val1 <= next_val1;
                val2 <= next_val2;
            end
        end
    end

    // outputs straight from channel flops
    assign O_CH1_VALUE1 = ch[0].val1;
    assign O_CH1_VALUE2 = ch[0].val2;
    assign O_CH2_VALUE1 = ch[1].val1;
    assign O_CH2_VALUE2 = ch[1].val2;
    assign O_CH1_CMD_ERR = ch[0].cmd_err;
    assign O_CH2_CMD_ERR = ch[1].cmd_err;
    assign O_CH1_CFG_ERR = ch[0].cfg_err;
    assign O_CH2_CFG_ERR = ch[1].cfg_err;
    assign O_CH1_CAPTURED = ch[0].captured;
    assign O_CH2_CAPTURED = ch[1].captured;
    assign O_CH1_IN_STATE = ch[0].in_prev;
    assign O_CH2_IN_STATE = ch[1].in_prev;
    assign O_CH1_LED_OFF = ch[0].cfg[`DSC_CFG_LED];
    assign O_CH2_LED_OFF = ch[1].cfg[`DSC_CFG_LED];
    assign O_CH1_CLK_RATE =
        ch[0].cfg[`DSC_CFG_RATE_HI:`DSC_CFG_RATE_LO];
    assign O_CH2_CLK_RATE =
        ch[1].cfg[`DSC_CFG_RATE_HI:`DSC_CFG_RATE_LO];
endmodule
`default_nettype wire

// ==== bench/dsc_cmd_cfg_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module dsc_cmd_cfg_chk (
    input wire logic        I_CLOCK,
    input wire logic        I_NRST,
    input wire logic [15:0] I_CMD,
    input wire logic [15:0] I_CH1_CFG,
    input wire logic        O_ACK,
    input wire logic        O_CH1_CMD_ERR,
    input wire logic        O_CH2_CMD_ERR,
    input wire logic        O_CH1_CFG_ERR,
    input wire logic        O_CH1_LED_OFF,
    input wire logic [1:0]  O_CH1_CLK_RATE
);
    logic prev_x;
    logic acc;
    logic ok1;
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_NRST);
    // transmit bit seen at the last edge, reset like the block's own
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            prev_x <= 1'h0;
        end else begin
            prev_x <= I_CMD[15];
        end
    end
    // accepted rise, and a clean setup write of channel 1
    assign acc = I_CMD[15] && !prev_x && !O_ACK;
    assign ok1 = acc && I_CMD[13:6] == 8'h00 && I_CMD[0]
        && I_CH1_CFG[7:4] <= 4'h6 && I_CH1_CFG[3:0] <= 4'h4;
    ack_set_a: assert property (acc |=> O_ACK)
        else $error("ack missing after transmit rise");
    ack_idle_a: assert property (!O_ACK && !acc |=> !O_ACK)
        else $error("ack without transmit rise");
    ack_hold_a: assert property (O_ACK && I_CMD[15] |=> O_ACK)
        else $error("ack dropped early");
    ack_drop_a: assert property (O_ACK && !I_CMD[15] |=> !O_ACK)
        else $error("ack held too long");
    cmd_err_a: assert property (
        acc && I_CMD[13:6] != 8'h00 |=> O_CH1_CMD_ERR && O_CH2_CMD_ERR)
        else $error("command error not flagged");
    err_keep_a: assert property (
        !acc |=> $stable(O_CH1_CMD_ERR) && $stable(O_CH1_CFG_ERR))
        else $error("error flag changed outside a cycle");
    cfg_bad_a: assert property (
        acc && I_CMD[13:6] == 8'h00 && I_CMD[0] && I_CH1_CFG[3:0] > 4'h4
        |=> O_CH1_CFG_ERR) else $error("reserved layout accepted");
    cfg_good_a: assert property (ok1 |=> !O_CH1_CFG_ERR)
        else $error("error flag kept after valid write");
    led_rate_a: assert property (
        ok1 |=> O_CH1_LED_OFF == $past(I_CH1_CFG[15])
        && O_CH1_CLK_RATE == $past(I_CH1_CFG[13:12]))
        else $error("setup bits not latched");
endmodule
`default_nettype wire

// ==== bench/dsc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dsc_host_model (
    input  wire logic   i_clock,
    input  wire logic   i_ack,
    output logic [15:0] o_cmd,
    output logic        o_lost
);
    // idle request word, no lost handshake yet
    task automatic idle();
        o_cmd = 16'h0000;
        o_lost = 1'h0;
    endtask
    // one cycle: raise transmit, hold past ack, release, wait ack low
    task automatic run(input logic [15:0] cmd);
        int n;
        o_cmd = cmd | 16'h8000;
        n = 0;
        while (i_ack !== 1'h1 && n < 20) begin
            @(negedge i_clock);
            n++;
        end
        @(negedge i_clock);
        o_cmd = 16'h0000;
        while (i_ack !== 1'h0 && n < 40) begin
            @(negedge i_clock);
            n++;
        end
        o_lost = o_lost | (n >= 20);
        repeat (2) @(negedge i_clock);
    endtask
endmodule
`default_nettype wire

// ==== bench/dsc_cmd_cfg_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module dsc_cmd_cfg_bench;
    logic        clock;
    logic        nrst;
    logic [15:0] cmd, cfg1, cfg2;
    logic [31:0] pre1, pre2, enc1, enc2;
    logic [31:0] v11, v12, v21, v22;
    logic        in1, in2, ack, lost, proto;
    logic        cerr1, cerr2, ferr1, ferr2, cap1, cap2;
    logic        ins1, ins2, led1, led2;
    logic [1:0]  rate1, rate2;
    int          checked = 0;
    int          miscompares = 0;
    int          cycles = 0;
    dsc_host_model host_u (.i_clock(clock), .i_ack(ack), .o_cmd(cmd),
        .o_lost(lost));
    dsc_cmd_cfg #(.VEL_SLOW_CYC(20), .VEL_FAST_CYC(8)) dut_u (
        .I_CLOCK(clock), .I_NRST(nrst), .I_CMD(cmd),
        .I_CH1_CFG(cfg1), .I_CH2_CFG(cfg2),
        .I_CH1_PRESET(pre1), .I_CH2_PRESET(pre2),
        .I_CH1_ENC(enc1), .I_CH2_ENC(enc2),
        .I_CH1_IN(in1), .I_CH2_IN(in2), .I_PROTO_HIGH_FIRST(proto),
        .O_ACK(ack), .O_CH1_VALUE1(v11), .O_CH1_VALUE2(v12),
        .O_CH2_VALUE1(v21), .O_CH2_VALUE2(v22),
        .O_CH1_CMD_ERR(cerr1), .O_CH2_CMD_ERR(cerr2),
        .O_CH1_CFG_ERR(ferr1), .O_CH2_CFG_ERR(ferr2),
        .O_CH1_CAPTURED(cap1), .O_CH2_CAPTURED(cap2),
        .O_CH1_IN_STATE(ins1), .O_CH2_IN_STATE(ins2),
        .O_CH1_LED_OFF(led1), .O_CH2_LED_OFF(led2),
        .O_CH1_CLK_RATE(rate1), .O_CH2_CLK_RATE(rate2));
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // quiet inputs before reset ends
    task automatic idle_inputs();
        {cfg1, cfg2, pre1, pre2, enc2, in1, in2, proto} = '0;
        enc1 = 32'h0000_1234;
    endtask
    // values straight after reset
    task automatic reset_values();
        check(ack, 1'h0);
        check(rate1, 2'h0);
        check(v11, 32'h0000_1234);
        check(v12, 32'h0000_1234);
    endtask
    // channel 2 decoding options one at a time
    task automatic ch2_decode();
        logic [15:0] c [4] = '{16'h0100, 16'h0200, 16'h0400, 16'h4000};
        logic [31:0] e [4] = '{32'h0000_1234, 32'h0000_0003,
            32'h0000_0003, 32'h0001_0002};
        logic [31:0] x [4] = '{32'hffff_edcb, 32'h0000_0002,
            32'hffff_fffd, 32'h0002_0001};
        for (int i = 0; i < 4; i++) begin
            cfg2 = c[i];
            enc2 = e[i];
            host_u.run(16'h0002);
            check(v21, x[i]);
        end
    endtask
    // capture on rising input, held while flag stands
    task automatic capture_ch2();
        cfg2 = 16'h0043;
        enc2 = 32'h0000_0050;
        host_u.run(16'h0022);
        in2 = 1'h1;
        repeat (3) @(negedge clock);
        check(ins2, 1'h1);
        check(cap2, 1'h1);
        check(v22, 32'h0000_0050);
        enc2 = 32'h0000_0060;
        in2 = 1'h0;
        repeat (2) @(negedge clock);
        in2 = 1'h1;
        repeat (3) @(negedge clock);
        check(v22, 32'h0000_0050);
        check(v21, 32'h0000_0060);
    endtask
    // new presets stored and applied on both channels at once
    task automatic preset_both();
        cfg1 = 16'h0000;
        cfg2 = 16'h0000;
        pre1 = 32'h0000_0100;
        pre2 = 32'h0000_0200;
        host_u.run(16'h000f);
        check(cap2, 1'h0);
        check(v11, 32'h0000_0100);
        check(v21, 32'h0000_0200);
        enc1 = enc1 + 32'h5;
        repeat (2) @(negedge clock);
        check(v11, 32'h0000_0105);
    endtask
    // rejected command, reserved layout, then clean write
    task automatic errors();
        host_u.run(16'h0044);
        check(cerr1, 1'h1);
        check(cerr2, 1'h1);
        check(v11, 32'h0000_0105);
        cfg1 = 16'h0005;
        host_u.run(16'h0001);
        check(cerr1, 1'h0);
        check(ferr1, 1'h1);
        check(ferr2, 1'h0);
        cfg1 = 16'hb000;
        host_u.run(16'h0001);
        check(ferr1, 1'h0);
        check(led1, 1'h1);
        check(rate1, 2'h3);
    endtask
    // velocity at slow then fast period with a steady ramp
    task automatic velocity();
        cfg1 = 16'h0001;
        host_u.run(16'h0010);
        repeat (60) @(negedge clock) enc1 = enc1 + 32'h1;
        check(v12, 32'h0000_0014);
        cfg1 = 16'h0801;
        host_u.run(16'h0001);
        repeat (30) @(negedge clock) enc1 = enc1 + 32'h1;
        check(v12, 32'h0000_0008);
    endtask
    // discrete input on channel 1, both channels written at once
    task automatic input_ch1();
        cfg1 = 16'h0020;
        cfg2 = 16'h9000;
        pre1 = 32'h0000_0700;
        host_u.run(16'h0013);
        check(led2, 1'h1);
        check(rate2, 2'h1);
        check(ferr2, 1'h0);
        in1 = 1'h1;
        repeat (3) @(negedge clock);
        check(ins1, 1'h1);
        check(v11, 32'h0000_015f);
        in1 = 1'h0;
        repeat (3) @(negedge clock);
        check(v11, 32'h0000_0700);
        cfg1 = 16'h0064;
        host_u.run(16'h0011);
        check(cap1, 1'h0);
        in1 = 1'h1;
        repeat (3) @(negedge clock);
        check(cap1, 1'h1);
        check(v12, 32'h0000_0700);
        proto = 1'h1;
        repeat (2) @(negedge clock);
        check(v12, 32'h0700_0000);
    endtask
    // clock
    initial begin
        clock = 1'h0;
        forever #25 clock = ~clock;
    end
    // hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            stop_test();
        end
    end
    // main sequence
    initial begin
        nrst = 1'h0;
        host_u.idle();
        idle_inputs();
        repeat (10) @(negedge clock);
        nrst = 1'h1;
        repeat (2) @(negedge clock);
        reset_values();
        ch2_decode();
        capture_ch2();
        preset_both();
        errors();
        velocity();
        input_ch1();
        check(lost, 1'h0);
        stop_test();
    end
endmodule
bind dsc_cmd_cfg dsc_cmd_cfg_chk chk_u (.I_CLOCK(I_CLOCK), .I_NRST(I_NRST),
    .I_CMD(I_CMD), .I_CH1_CFG(I_CH1_CFG), .O_ACK(O_ACK),
    .O_CH1_CMD_ERR(O_CH1_CMD_ERR), .O_CH2_CMD_ERR(O_CH2_CMD_ERR),
    .O_CH1_CFG_ERR(O_CH1_CFG_ERR), .O_CH1_LED_OFF(O_CH1_LED_OFF),
    .O_CH1_CLK_RATE(O_CH1_CLK_RATE));
`default_nettype wire
